// file: verilog/obcfg_defs.svh
// Constants for the option byte configuration loader: field positions,
// default byte contents, byte selects.
// Assumes it is included by bare name from the package and the loader.
`ifndef OBCFG_DEFS_SVH
`define OBCFG_DEFS_SVH

// Option byte 1 (startup and supervision) field positions
`define OBCFG_CLKSRC_HI 7
`define OBCFG_CLKSRC_LO 6
`define OBCFG_B1_RSV_ONE 5
`define OBCFG_B1_RSV_ZERO 4
`define OBCFG_BOD_HI 3
`define OBCFG_BOD_LO 2
`define OBCFG_WD_TYPE_BIT 1
`define OBCFG_WD_HALT_BIT 0

// Option byte 0 (memory layout) field positions
`define OBCFG_B0_RSV_HI 7
`define OBCFG_B0_RSV_LO 4
`define OBCFG_SECTOR_HI 3
`define OBCFG_SECTOR_LO 2
`define OBCFG_B0_RSV_ONES 4'hF

// Erased or shipped contents of each byte
`define OBCFG_B0_DEFAULT 8'hF0
`define OBCFG_B1_DEFAULT 8'h2F

// Byte select on the programming port
`define OBCFG_SEL_MEMORY_LAYOUT 1'h0
`define OBCFG_SEL_STARTUP 1'h1

// Read data returned for a refused access
`define OBCFG_RDATA_NONE 8'h00

`endif

// file: verilog/obcfg_pkg.sv
// Types shared by the option byte configuration loader and its bench.
// Assumes obcfg_defs.svh is on the include path.
`default_nettype none
`include "obcfg_defs.svh"

package obcfg_pkg;

   // Startup clock choice, encoded as stored in the option byte
   typedef enum logic [1:0] {
      OBCFG_CLK_INT_RC = 2'h0,
      OBCFG_CLK_WAKEUP_RC = 2'h1,
      OBCFG_CLK_RESERVED = 2'h2,
      OBCFG_CLK_EXTERNAL = 2'h3
   } obcfg_clk_src_t;

   // Brownout detector setting, encoded as stored
   typedef enum logic [1:0] {
      OBCFG_BOD_LOWEST = 2'h0,
      OBCFG_BOD_MEDIUM = 2'h1,
      OBCFG_BOD_HIGHEST = 2'h2,
      OBCFG_BOD_OFF = 2'h3
   } obcfg_bod_t;

   // Decoded size of sector 0
   typedef enum logic [1:0] {
      OBCFG_SECTOR_HALF_K = 2'h0,
      OBCFG_SECTOR_ONE_K = 2'h1,
      OBCFG_SECTOR_TWO_K = 2'h2
   } obcfg_sector_size_t;

endpackage

`default_nettype wire

// file: verilog/obcfg_loader.sv
// Option byte configuration loader: gives a programming port onto the two
// option bytes and decodes them into static hardware configuration.
// Assumes the non-volatile cells sit outside and are presented on nv_*_i,
// and that the programming controller runs on sys_clk_i.
//
// Overview of operation
// - Option bytes readable or writable only in programming mode, never otherwise.
// - Byte 1 bits 7:6: 00 internal RC, 01 wake-up RC, 11 external, 10 reserved.
// - Byte 1 bits 3:2: 11 off, 10 highest, 01 medium, 00 lowest threshold.
// - Byte 1 bit 1: 0 hardware watchdog always on, 1 software enabled.
// - Byte 1 bit 0 set: halt entry with active watchdog causes reset.
// - Byte 0 bits 3:2: 00 half K, bit3 only 1K, bit2 set 2K.
`timescale 1ns/100ps
`default_nettype none
`include "obcfg_defs.svh"

module obcfg_loader (
   input wire logic sys_clk_i, // 20 MHz system clock
   input wire logic reset_i, // Synchronous reset, active high
   input wire logic prog_pin_i, // Programming mode entry pin, asynchronous
   input wire logic prog_rd_i, // Read request pulse
   input wire logic prog_wr_i, // Write request pulse
   input wire logic prog_sel_i, // Byte select, 1 = startup byte
   input wire logic [7:0] prog_wdata_i, // Write data
   input wire logic [7:0] nv_memory_layout_i, // Stored option byte 0
   input wire logic [7:0] nv_startup_i, // Stored option byte 1
   input wire logic halt_entry_i, // Core enters halt, one-cycle pulse
   input wire logic watchdog_sw_enable_i, // Software has started the watchdog
   output logic prog_mode_o, // Filtered programming mode level
   output logic [7:0] prog_rdata_o, // Read data
   output logic prog_ack_o, // Request accepted, one-cycle pulse
   output logic prog_refused_o, // Request refused, one-cycle pulse
   output logic nv_wr_o, // Program pulse to the cells
   output logic nv_wsel_o, // Byte written by nv_wr_o
   output logic [7:0] nv_wdata_o, // Data written by nv_wr_o
   output var obcfg_pkg::obcfg_clk_src_t startup_clock_select_o, // Startup clock
   output var obcfg_pkg::obcfg_bod_t brownout_threshold_select_o, // Detector setting
   output logic brownout_enable_o, // Detector switched on
   output logic watchdog_hw_or_sw_select_o, // 1 = software watchdog
   output logic watchdog_always_on_o, // Hardware watchdog forced on
   output logic halt_reset_enable_o, // Halt reset option
   output logic halt_reset_o, // Reset request on halt, one-cycle pulse
   output var obcfg_pkg::obcfg_sector_size_t sector0_size_select_o, // Sector 0 size
   output logic option_fault_o // Reserved bits or code found in stored bytes
);

   // ==========================================================================
   // Decoding functions
   // ==========================================================================

   // Bit 2 set gives the largest sector whatever bit 3 holds
   function automatic obcfg_pkg::obcfg_sector_size_t sector_decode(input logic [7:0] b0);
      obcfg_pkg::obcfg_sector_size_t size;
      size = obcfg_pkg::OBCFG_SECTOR_HALF_K;
      if (b0[`OBCFG_SECTOR_LO]) begin
         size = obcfg_pkg::OBCFG_SECTOR_TWO_K;
      end else if (b0[`OBCFG_SECTOR_HI]) begin
         size = obcfg_pkg::OBCFG_SECTOR_ONE_K;
      end
      return size;
   endfunction

   // Reserved clock code falls back to the internal RC so the part still starts
   function automatic obcfg_pkg::obcfg_clk_src_t clk_decode(input logic [7:0] b1);
      obcfg_pkg::obcfg_clk_src_t src;
      src = obcfg_pkg::obcfg_clk_src_t'(b1[`OBCFG_CLKSRC_HI:`OBCFG_CLKSRC_LO]);
      if (src == obcfg_pkg::OBCFG_CLK_RESERVED) begin
         src = obcfg_pkg::OBCFG_CLK_INT_RC;
      end
      return src;
   endfunction

   // Flags reserved patterns in the stored bytes; the part still starts on the
   // safe decodes, so this is a warning for the system, not a stop
   function automatic logic fault_check(input logic [7:0] b0, input logic [7:0] b1);
      logic bad;
      bad = (b1[`OBCFG_CLKSRC_HI:`OBCFG_CLKSRC_LO] == obcfg_pkg::OBCFG_CLK_RESERVED);
      bad = bad | ~b1[`OBCFG_B1_RSV_ONE];
      bad = bad | b1[`OBCFG_B1_RSV_ZERO];
      bad = bad | (b0[`OBCFG_B0_RSV_HI:`OBCFG_B0_RSV_LO] != `OBCFG_B0_RSV_ONES);
      return bad;
   endfunction

   // ==========================================================================
   // Programming mode pin filter
   // ==========================================================================

   logic prog_s1;
   logic prog_s2;
   logic prog_s3;

   // Reset clears the chain so a held pin re-enters programming mode cleanly
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         prog_s1 <= 1'b0;
         prog_s2 <= 1'b0;
         prog_s3 <= 1'b0;
      end else begin
         prog_s1 <= prog_pin_i;
         prog_s2 <= prog_s1;
         prog_s3 <= prog_s2;
      end
   end

   // A level change counts only once the two later stages agree
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         prog_mode_o <= 1'b0;
      end else if (prog_s2 == prog_s3) begin
         prog_mode_o <= prog_s3;
      end
   end

   // ==========================================================================
   // Programming port
   // ==========================================================================

   logic access_ok;
   logic any_req;

   // Write wins over read when both arrive; only one answer pulse results
   assign any_req = prog_rd_i | prog_wr_i;
   assign access_ok = prog_mode_o;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         prog_ack_o <= 1'b0;
         prog_refused_o <= 1'b0;
      end else begin
         prog_ack_o <= any_req & access_ok;
         prog_refused_o <= any_req & ~access_ok;
      end
   end

   // Read data stands until the next read request; refused reads return zero
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         prog_rdata_o <= `OBCFG_RDATA_NONE;
      end else if (prog_rd_i & ~prog_wr_i) begin
         if (!access_ok) begin
            prog_rdata_o <= `OBCFG_RDATA_NONE;
         end else if (prog_sel_i == `OBCFG_SEL_STARTUP) begin
            prog_rdata_o <= nv_startup_i;
         end else begin
            prog_rdata_o <= nv_memory_layout_i;
         end
      end
   end

   // Data is passed to the cells as given; reserved bit values are the
   // programmer's duty and are only flagged after the next reset
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         nv_wr_o <= 1'b0;
         nv_wsel_o <= `OBCFG_SEL_MEMORY_LAYOUT;
         nv_wdata_o <= `OBCFG_RDATA_NONE;
      end else begin
         nv_wr_o <= prog_wr_i & access_ok;
         if (prog_wr_i & access_ok) begin
            nv_wsel_o <= prog_sel_i;
            nv_wdata_o <= prog_wdata_i;
         end
      end
   end

   // ==========================================================================
   // Configuration captured during reset
   // ==========================================================================

   // Cells are sampled every cycle while reset is high, so the last cycle of
   // reset decides; writes made later take effect only at the next reset.
   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         startup_clock_select_o <= clk_decode(nv_startup_i);
         option_fault_o <= fault_check(nv_memory_layout_i, nv_startup_i);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         brownout_threshold_select_o <= obcfg_pkg::obcfg_bod_t'(
            nv_startup_i[`OBCFG_BOD_HI:`OBCFG_BOD_LO]);
         brownout_enable_o <= (nv_startup_i[`OBCFG_BOD_HI:`OBCFG_BOD_LO]
            != obcfg_pkg::OBCFG_BOD_OFF);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         watchdog_hw_or_sw_select_o <= nv_startup_i[`OBCFG_WD_TYPE_BIT];
         // Hardware watchdog choice is the complement of the type bit
         watchdog_always_on_o <= ~nv_startup_i[`OBCFG_WD_TYPE_BIT];
         halt_reset_enable_o <= nv_startup_i[`OBCFG_WD_HALT_BIT];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         sector0_size_select_o <= sector_decode(nv_memory_layout_i);
      end
   end

   // ==========================================================================
   // Reset on halt
   // ==========================================================================

   logic watchdog_active;

   // The software start only matters when the option left the watchdog to software
   assign watchdog_active = watchdog_always_on_o | watchdog_sw_enable_i;

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         halt_reset_o <= 1'b0;
      end else begin
         halt_reset_o <= halt_entry_i & watchdog_active & halt_reset_enable_o;
      end
   end

endmodule

`default_nettype wire

// file: testbench/obcfg_loader_properties.sv
// Port checker for the option byte loader, bound to every loader instance.
// Assumes obcfg_pkg is compiled before this file.
`timescale 1ns/100ps
`default_nettype none
// ==================================
// Checker
module obcfg_chk (
   input wire logic sys_clk_i, // Clock
   input wire logic reset_i, // Reset
   input wire logic prog_rd_i, // Read
   input wire logic prog_wr_i, // Write
   input wire logic prog_sel_i, // Byte select
   input wire logic [7:0] prog_wdata_i, // Write data
   input wire logic [7:0] nv_memory_layout_i, // Byte 0
   input wire logic [7:0] nv_startup_i, // Byte 1
   input wire logic halt_entry_i, // Halt
   input wire logic watchdog_sw_enable_i, // Sw start
   input wire logic prog_mode_o, // Mode
   input wire logic [7:0] prog_rdata_o, // Read data
   input wire logic prog_ack_o, // Ack
   input wire logic prog_refused_o, // Refused
   input wire logic nv_wr_o, // Cell write
   input wire logic nv_wsel_o, // Cell select
   input wire logic [7:0] nv_wdata_o, // Cell data
   input wire logic [1:0] startup_clock_select_o, // Clock
   input wire logic [1:0] brownout_threshold_select_o, // Detector
   input wire logic brownout_enable_o, // Detector on
   input wire logic watchdog_hw_or_sw_select_o, // Sw watchdog
   input wire logic watchdog_always_on_o, // Hw watchdog
   input wire logic halt_reset_enable_o, // Halt option
   input wire logic halt_reset_o, // Halt reset
   input wire logic [1:0] sector0_size_select_o // Sector
);
   default clocking @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);
   a_req_answer: assert property (prog_rd_i || prog_wr_i |=>
      prog_ack_o == $past(prog_mode_o) && prog_refused_o == !$past(prog_mode_o)
      && nv_wr_o == ($past(prog_wr_i) && $past(prog_mode_o))) else $error("bad answer");
   a_read_data: assert property (prog_rd_i && !prog_wr_i |=> prog_rdata_o ==
      (!$past(prog_mode_o) ? 8'h00 : $past(prog_sel_i) ? $past(nv_startup_i)
      : $past(nv_memory_layout_i))) else $error("bad read data");
   a_write_cells: assert property (prog_wr_i && prog_mode_o |=>
      nv_wsel_o == $past(prog_sel_i) && nv_wdata_o == $past(prog_wdata_i))
      else $error("bad cell write");
   a_clock_decode: assert property ($fell(reset_i) |-> startup_clock_select_o ==
      ($past(nv_startup_i[7:6]) == 2'h2 ? 2'h0 : $past(nv_startup_i[7:6])))
      else $error("bad clock decode");
   a_detector_decode: assert property ($fell(reset_i) |->
      brownout_threshold_select_o == $past(nv_startup_i[3:2])
      && brownout_enable_o == ($past(nv_startup_i[3:2]) != 2'h3)) else $error("bad detector");
   a_watchdog_decode: assert property ($fell(reset_i) |->
      {watchdog_hw_or_sw_select_o, watchdog_always_on_o, halt_reset_enable_o} ==
      {$past(nv_startup_i[1]), !$past(nv_startup_i[1]), $past(nv_startup_i[0])})
      else $error("bad watchdog decode");
   a_halt_reset: assert property (halt_entry_i |=> halt_reset_o ==
      ($past(halt_reset_enable_o) && ($past(watchdog_always_on_o)
      || $past(watchdog_sw_enable_i)))) else $error("bad halt reset");
   a_sector_decode: assert property ($fell(reset_i) |-> sector0_size_select_o ==
      ($past(nv_memory_layout_i[2]) ? 2'h2 : {1'b0, $past(nv_memory_layout_i[3])}))
      else $error("bad sector decode");
   a_config_hold: assert property (!$past(reset_i) |-> $stable({startup_clock_select_o,
      brownout_threshold_select_o, sector0_size_select_o, watchdog_always_on_o,
      halt_reset_enable_o})) else $error("settings moved");
endmodule
bind obcfg_loader obcfg_chk obcfg_chk_i (.sys_clk_i, .reset_i, .prog_rd_i, .prog_wr_i,
   .prog_sel_i, .prog_wdata_i, .nv_memory_layout_i, .nv_startup_i, .halt_entry_i,
   .watchdog_sw_enable_i, .prog_mode_o, .prog_rdata_o, .prog_ack_o, .prog_refused_o,
   .nv_wr_o, .nv_wsel_o, .nv_wdata_o, .startup_clock_select_o, .brownout_threshold_select_o,
   .brownout_enable_o, .watchdog_hw_or_sw_select_o, .watchdog_always_on_o,
   .halt_reset_enable_o, .halt_reset_o, .sector0_size_select_o);
`default_nettype wire

// file: testbench/obcfg_tool.sv
// Programming tool model: single byte requests on the loader's port.
// Assumes requests launch on the falling edge of the shared clock.
`timescale 1ns/100ps
`default_nettype none
// ==================================
// Tool
module obcfg_tool (
   input wire logic clk_i, // Clock
   input wire logic ack_i, // Accepted
   input wire logic refused_i, // Refused
   input wire logic [7:0] rdata_i, // Read data
   output var logic rd_o, // Read pulse
   output var logic wr_o, // Write pulse
   output var logic sel_o, // Byte select
   output var logic [7:0] wdata_o // Write data
);
   initial {rd_o, wr_o, sel_o, wdata_o} = 11'h000;
   task automatic xfer(input logic w, s, input logic [7:0] d, output logic [7:0] q,
                       output logic [1:0] st);
      @(negedge clk_i);
      rd_o = !w;
      wr_o = w;
      sel_o = s;
      wdata_o = s ? {d[7:6], 2'b10, d[3:0]} : {4'hF, d[3:0]};
      @(negedge clk_i);
      // The answer stands for one cycle only, so it is taken before release
      q = rdata_i;
      st = {ack_i, refused_i};
      {rd_o, wr_o} = 2'b00;
      // Released data is inverted so stale values cannot pass as valid
      wdata_o = ~wdata_o;
   endtask
endmodule
`default_nettype wire

// file: testbench/option_byte_configuration_tb.sv
// Self-checking bench for the option byte loader with a cell array model.
// Assumes the loader, its package, checker and tool model are compiled first.
`timescale 1ns/100ps
`default_nettype none
// ==================================
// Bench
module option_byte_configuration_tb;
   logic sys_clk_i = 0, reset_i = 1, pin = 0, halt = 0, sw_en = 0;
   logic rd, wr, sel, ack, refused, mode, nv_wr, nv_wsel, halt_rst, bod_en, wd_sw, wd_on, h_en;
   logic fault;
   logic [7:0] wdata, rdata, nv_wdata, cell0 = 8'hF0, cell1 = 8'h2F;
   logic [1:0] clk_sel, bod, sector;
   int n_errors = 0, checks_done = 0;
   initial forever #25 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i)
      if (nv_wr && nv_wsel) cell1 <= nv_wdata;
      else if (nv_wr) cell0 <= nv_wdata;
   obcfg_tool obcfg_tool_i (.clk_i(sys_clk_i), .ack_i(ack), .refused_i(refused),
      .rdata_i(rdata), .rd_o(rd), .wr_o(wr), .sel_o(sel), .wdata_o(wdata));
   obcfg_loader obcfg_loader_i (.sys_clk_i, .reset_i, .prog_pin_i(pin), .prog_rd_i(rd),
      .prog_wr_i(wr), .prog_sel_i(sel), .prog_wdata_i(wdata), .nv_memory_layout_i(cell0),
      .nv_startup_i(cell1), .halt_entry_i(halt), .watchdog_sw_enable_i(sw_en),
      .prog_mode_o(mode), .prog_rdata_o(rdata), .prog_ack_o(ack), .prog_refused_o(refused),
      .nv_wr_o(nv_wr), .nv_wsel_o(nv_wsel), .nv_wdata_o(nv_wdata),
      .startup_clock_select_o(clk_sel), .brownout_threshold_select_o(bod),
      .brownout_enable_o(bod_en), .watchdog_hw_or_sw_select_o(wd_sw),
      .watchdog_always_on_o(wd_on), .halt_reset_enable_o(h_en), .halt_reset_o(halt_rst),
      .sector0_size_select_o(sector), .option_fault_o(fault));
   task automatic chk(input string nm, input logic [7:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic do_reset;
      reset_i = 1;
      repeat (8) @(negedge sys_clk_i);
      reset_i = 0;
      repeat (6) @(negedge sys_clk_i);
   endtask
   initial begin
      #200000;
      n_errors++;
      close_out;
   end
   initial begin
      logic [7:0] b1, q;
      logic [1:0] st, cs;
      cs = 2'h0;
      do_reset;
      chk("detector", {bod_en, bod}, 8'h03);
      obcfg_tool_i.xfer(1'b0, 1'b1, 8'h00, q, st);
      chk("idle status", st, 8'h01);
      chk("idle data", q, 8'h00);
      pin = 1;
      repeat (6) @(negedge sys_clk_i);
      chk("mode on", mode, 8'h01);
      for (int i = 0; i < 4; i++) begin
         b1 = {i[1:0], 2'b10, i[1:0], i[0], i[1]};
         obcfg_tool_i.xfer(1'b1, 1'b1, b1, q, st);
         chk("write status", st, 8'h02);
         obcfg_tool_i.xfer(1'b1, 1'b0, {4'h0, i[0], i[1], 2'h0}, q, st);
         obcfg_tool_i.xfer(1'b0, 1'b1, 8'h00, q, st);
         chk("read status", st, 8'h02);
         chk("read back", q, b1);
         chk("held clock", clk_sel, cs);
         do_reset;
         cs = (i == 2) ? 2'h0 : i[1:0];
         chk("clock", clk_sel, cs);
         chk("fault", fault, i == 2);
         chk("detector", {bod_en, bod}, {i != 3, i[1:0]});
         chk("watchdog", {wd_sw, wd_on, h_en}, {i[0], !i[0], i[1]});
         chk("sector", sector, i[1] ? 8'h02 : {7'h00, i[0]});
         for (int s = 0; s < 2; s++) begin
            sw_en = s[0];
            halt = 1;
            @(negedge sys_clk_i);
            chk("halt reset", halt_rst, i[1] && (!i[0] || s[0]));
            halt = 0;
            @(negedge sys_clk_i);
            chk("halt pulse end", halt_rst, 8'h00);
         end
      end
      pin = 0;
      repeat (6) @(negedge sys_clk_i);
      chk("mode off", mode, 8'h00);
      obcfg_tool_i.xfer(1'b1, 1'b0, 8'h00, q, st);
      chk("late status", st, 8'h01);
      close_out;
   end
endmodule
`default_nettype wire
